// ===== core/fpnl_alu.v
`include "fpnl_map.vh"

module fpnl_alu (
   input  wire [31:0] insn,
   input  wire [31:0] valS,
   input  wire [31:0] valA,
   input  wire [31:0] valB,
   input  wire [2:0]  xerIn,
   output reg  [31:0] result,
   output reg  [4:0]  destIdx,
   output reg         regWe,
   output reg  [2:0]  xerOut,
   output reg  [3:0]  cr0Out,
   output reg         cr0We,
   output reg         ovfEvent,
   output reg         illegal
);

   // fields are numbered from the msb, bit 0 is insn[31]
   wire [5:0] primary  = insn[31:26];
   wire [4:0] fieldS   = insn[25:21];
   wire [4:0] fieldA   = insn[20:16];
   wire       ovEnable = insn[10];
   wire [9:0] xo10     = insn[10:1];
   wire [8:0] xo9      = insn[9:1];
   wire       recordBit = insn[0];

   // signed compare against zero, summary copied in
   function [3:0] crOf;
      input [31:0] val;
      input        so;
      begin
         crOf[`FPNL_CR_LESS]    = val[31];
         crOf[`FPNL_CR_GREATER] = ~val[31] & (|val);
         crOf[`FPNL_CR_ZERO]    = ~(|val);
         crOf[`FPNL_CR_SO] = so;
      end
   endfunction

   reg [31:0] negVal;
   reg        isMostNeg;

   always @* begin
      negVal    = (~valA) + `FPNL_ONE;
      isMostNeg = (valA == `FPNL_MOST_NEG);
      result    = `FPNL_RST_WORD;
      destIdx   = fieldA;
      regWe     = 1'b0;
      xerOut    = xerIn;
      ovfEvent  = 1'b0;
      illegal   = 1'b0;
      if (primary != `FPNL_PRIMARY) begin
         illegal = 1'b1;
      end else if (xo10 == `FPNL_XO_NAND) begin
         result  = ~(valS & valB);
         destIdx = fieldA;
         regWe   = 1'b1;
         xerOut  = xerIn;
      end else if (xo10 == `FPNL_XO_NOR) begin
         result  = ~(valS | valB);
         destIdx = fieldA;
         regWe   = 1'b1;
      end else if (xo9 == `FPNL_XO_NEG) begin
         result  = negVal;
         destIdx = fieldS;
         regWe   = 1'b1;
         if (ovEnable) begin
            xerOut[`FPNL_XER_OVF] = isMostNeg;
            xerOut[`FPNL_XER_SO] = xerIn[`FPNL_XER_SO] | isMostNeg;
            ovfEvent             = isMostNeg;
         end
         xerOut[`FPNL_XER_CARRY] = xerIn[`FPNL_XER_CARRY];
      end else if (xo9 == `FPNL_XO_NABS) begin
         // negative values are already their own negative magnitude
         result  = valA[31] ? valA : negVal;
         destIdx = fieldS;
         regWe   = 1'b1;
         // overflow cleared even for most negative
         if (ovEnable) begin
            xerOut[`FPNL_XER_OVF] = 1'b0;
         end
      end else begin
         illegal = 1'b1;
      end
      cr0We  = recordBit & regWe;
      cr0Out = crOf(result, xerOut[`FPNL_XER_SO]);
   end

endmodule // fpnl_alu

// ===== core/fpnl_map.vh
`ifndef FPNL_MAP_VH
`define FPNL_MAP_VH

// byte offsets on the register bus (low eight address bits)
`define FPNL_OFF_GENREG    8'h00
`define FPNL_OFF_INSN      8'h80
`define FPNL_OFF_XER       8'h84
`define FPNL_OFF_CR0       8'h88
`define FPNL_OFF_STATUS    8'h8C
`define FPNL_OFF_CLEAR     8'h90
`define FPNL_OFF_ENABLE    8'h94
`define FPNL_OFF_RESULT    8'h98

// instruction decode values
`define FPNL_PRIMARY       6'h1F
`define FPNL_XO_NAND       10'h01DC
`define FPNL_XO_NOR        10'h007C
`define FPNL_XO_NEG        9'h068
`define FPNL_XO_NABS       9'h1E8
`define FPNL_MOST_NEG      32'h8000_0000
`define FPNL_ONE           32'h0000_0001

// exception flags, internal three-bit store
`define FPNL_XER_SO        2
`define FPNL_XER_OVF       1
`define FPNL_XER_CARRY     0
// the store sits at bus bits 31..29
`define FPNL_XER_LSB       29

// condition field 0, bus bits 3..0
`define FPNL_CR_LESS       3
`define FPNL_CR_GREATER    2
`define FPNL_CR_ZERO       1
`define FPNL_CR_SO         0

// event status bits
`define FPNL_EV_DONE       0
`define FPNL_EV_OVF        1
`define FPNL_EV_ILL        2
`define FPNL_EV_W          3

// reset values
`define FPNL_RST_XER       3'h0
`define FPNL_RST_CR0       4'h0
`define FPNL_RST_ENABLE    3'h0
`define FPNL_RST_WORD      32'h0000_0000

// bus wait states for an instruction write (capture, execute)
`define FPNL_EXEC_WAIT     2

`endif

// ===== core/fpnl_unit.v
// The implementer's own choices: the AHB-Lite register port and the placing of the registers.
`include "fpnl_map.vh"

module fpnl_unit (
   input  wire        mclk,
   input  wire        rstn,
   input  wire        hsel,
   input  wire [31:0] haddr,
   input  wire [1:0]  htrans,
   input  wire        hwrite,
   input  wire [2:0]  hsize,
   input  wire [31:0] hwdata,
   input  wire        hready,
   output reg  [31:0] hrdata,
   output reg         hreadyout,
   output reg         hresp,
   output reg         irq
);

   localparam ST_IDLE = 2'd0;
   localparam ST_CAPT = 2'd1;
   localparam ST_EXEC = 2'd2;

   integer i;

   // general registers, word index 0..31
   reg [31:0] genRegQ [0:31];

   reg [1:0]  stateQ;
   reg [1:0]  stateD;
   reg        wrPendQ;
   reg [7:0]  wrAddrQ;
   reg [31:0] insnQ;
   reg [31:0] resultQ;
   reg [2:0]  xerQ;
   reg [2:0]  xerD;
   reg [3:0]  cr0Q;
   reg [3:0]  cr0D;
   reg [2:0]  statusQ;
   reg [2:0]  statusD;
   reg [2:0]  enableQ;
   reg [2:0]  enableD;
   reg [2:0]  evSet;
   reg [2:0]  evClr;
   reg [31:0] rdVal;

   wire        accept   = hsel & htrans[1] & hready;
   wire [7:0]  addrLow  = haddr[7:0];
   wire        addrGenReg = (haddr[7] == 1'b0);
   wire        dataWr     = wrPendQ & (stateQ == ST_IDLE);
   wire        wrGenReg   = dataWr & (wrAddrQ[7] == 1'b0);
   wire        exec     = (stateQ == ST_EXEC);

   wire [31:0] aluResult;
   wire [4:0]  aluDest;
   wire        aluRegWe;
   wire [2:0]  aluXer;
   wire [3:0]  aluCr0;
   wire        aluCr0We;
   wire        aluOvf;
   wire        aluIll;

   // register fields of the held instruction
   wire [4:0]  idxS = insnQ[25:21];
   wire [4:0]  idxA = insnQ[20:16];
   wire [4:0]  idxB = insnQ[15:11];

   fpnl_alu u_alu (
      .insn     (insnQ),
      .valS     (genRegQ[idxS]),
      .valA     (genRegQ[idxA]),
      .valB     (genRegQ[idxB]),
      .xerIn    (xerQ),
      .result   (aluResult),
      .destIdx  (aluDest),
      .regWe    (aluRegWe),
      .xerOut   (aluXer),
      .cr0Out   (aluCr0),
      .cr0We    (aluCr0We),
      .ovfEvent (aluOvf),
      .illegal  (aluIll)
   );

   // address decode, one word per register
   function isOff;
      input [7:0] addr;
      input [7:0] off;
      begin
         isOff = (addr[7:2] == off[7:2]);
      end
   endfunction

   // next values of the single registers; software writes only land
   // while idle and execution only while the bus is stalled, so the
   // two never meet in one cycle
   always @* begin
      xerD    = xerQ;
      cr0D    = cr0Q;
      enableD = enableQ;
      evSet   = 3'h0;
      evClr   = 3'h0;
      if (dataWr && isOff(wrAddrQ, `FPNL_OFF_XER)) begin
         xerD = hwdata[31:29];
      end
      if (dataWr && isOff(wrAddrQ, `FPNL_OFF_CR0)) begin
         cr0D = hwdata[3:0];
      end
      if (dataWr && isOff(wrAddrQ, `FPNL_OFF_ENABLE)) begin
         enableD = hwdata[2:0];
      end
      if (dataWr && isOff(wrAddrQ, `FPNL_OFF_CLEAR)) begin
         evClr = hwdata[2:0];
      end
      if (exec) begin
         xerD = aluXer;
         // field 0 only on record forms
         if (aluCr0We) begin
            cr0D = aluCr0;
         end
         evSet[`FPNL_EV_DONE] = 1'b1;
         evSet[`FPNL_EV_OVF]  = aluOvf;
         evSet[`FPNL_EV_ILL]  = aluIll;
      end
      // a clear in the cycle of an event loses to the event
      statusD = (statusQ & ~evClr) | evSet;
   end

   // read mux looks at next values so a read right behind a write
   // returns the new contents
   always @* begin
      rdVal = `FPNL_RST_WORD;
      if (addrGenReg) begin
         if (wrGenReg && (wrAddrQ[6:2] == haddr[6:2])) begin
            rdVal = hwdata;
         end else begin
            rdVal = genRegQ[haddr[6:2]];
         end
      end else if (isOff(addrLow, `FPNL_OFF_INSN)) begin
         rdVal = insnQ;
      end else if (isOff(addrLow, `FPNL_OFF_XER)) begin
         rdVal = {xerD, 29'h0000_0000};
      end else if (isOff(addrLow, `FPNL_OFF_CR0)) begin
         rdVal = {28'h000_0000, cr0D};
      end else if (isOff(addrLow, `FPNL_OFF_STATUS)) begin
         rdVal = {29'h0000_0000, statusD};
      end else if (isOff(addrLow, `FPNL_OFF_ENABLE)) begin
         rdVal = {29'h0000_0000, enableD};
      end else if (isOff(addrLow, `FPNL_OFF_RESULT)) begin
         rdVal = resultQ;
      end else begin
         rdVal = `FPNL_RST_WORD;
      end
   end

   // bus sequencer: instruction writes stall the data phase until
   // the result is written back
   always @* begin
      stateD = stateQ;
      case (stateQ)
         ST_IDLE: begin
            if (accept && hwrite && isOff(addrLow, `FPNL_OFF_INSN)) begin
               stateD = ST_CAPT;
            end
         end
         ST_CAPT: begin
            stateD = ST_EXEC;
         end
         ST_EXEC: begin
            stateD = ST_IDLE;
         end
         default: begin
            stateD = ST_IDLE;
         end
      endcase
   end

   always @(posedge mclk or negedge rstn) begin
      if (!rstn) begin
         stateQ    <= ST_IDLE;
         hreadyout <= 1'b1;
         hresp     <= 1'b0;
         hrdata    <= `FPNL_RST_WORD;
         wrPendQ   <= 1'b0;
         wrAddrQ   <= 8'h00;
      end else begin
         stateQ    <= stateD;
         hreadyout <= (stateD == ST_IDLE);
         // only OKAY is ever answered
         hresp     <= 1'b0;
         wrPendQ   <= 1'b0;
         if (accept && (stateQ == ST_IDLE)) begin
            if (hwrite) begin
               if (!isOff(addrLow, `FPNL_OFF_INSN)) begin
                  wrPendQ <= 1'b1;
                  wrAddrQ <= addrLow;
               end
            end else begin
               hrdata <= rdVal;
            end
         end
      end
   end

   // instruction capture and execution
   always @(posedge mclk or negedge rstn) begin
      if (!rstn) begin
         insnQ   <= `FPNL_RST_WORD;
         resultQ <= `FPNL_RST_WORD;
      end else begin
         if (stateQ == ST_CAPT) begin
            insnQ <= hwdata;
         end
         if (exec && aluRegWe) begin
            resultQ <= aluResult;
         end
      end
   end

   // general registers: bus write or writeback, never both at once
   always @(posedge mclk or negedge rstn) begin
      if (!rstn) begin
         for (i = 0; i < 32; i = i + 1) begin
            genRegQ[i] <= `FPNL_RST_WORD;
         end
      end else begin
         if (wrGenReg) begin
            genRegQ[wrAddrQ[6:2]] <= hwdata;
         end else if (exec && aluRegWe) begin
            genRegQ[aluDest] <= aluResult;
         end
      end
   end

   // flags, events and the interrupt line
   always @(posedge mclk or negedge rstn) begin
      if (!rstn) begin
         xerQ    <= `FPNL_RST_XER;
         cr0Q    <= `FPNL_RST_CR0;
         statusQ <= 3'h0;
         enableQ <= `FPNL_RST_ENABLE;
         irq     <= 1'b0;
      end else begin
         // carry passes through unchanged from the datapath
         xerQ    <= xerD;
         cr0Q    <= cr0D;
         statusQ <= statusD;
         enableQ <= enableD;
         irq     <= |(statusD & enableD);
      end
   end

endmodule // fpnl_unit

// ===== verif/fpnl_unit_bench.sv
module fpnl_unit_bench;
   timeunit 1ns;
   timeprecision 1ns;
   logic        mclk, rstn, hsel, hwrite;
   logic [31:0] haddr, hwdata, seed, rd, r, s;
   logic [1:0]  htrans;
   logic [2:0]  hsize, stat;
   logic [31:0] regs [32];
   logic        sumOvf, ovfFlag, carryFlag;
   logic [3:0]  cr;
   wire  [31:0] hrdata;
   wire         hreadyout, hresp, irq;
   int          mismatches, compares;

   fpnl_unit fpnl_unit_inst (.mclk(mclk), .rstn(rstn), .hsel(hsel),
      .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
      .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
      .hreadyout(hreadyout), .hresp(hresp), .irq(irq));

   function automatic logic [31:0] nx(input logic [31:0] x);
      nx = {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
   endfunction

   task print_verdict;
      if (mismatches == 0 && compares > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask

   task chk(input logic [31:0] g, input logic [31:0] e);
      compares++;
      if (g !== e) begin
         mismatches++;
         $display("MISMATCH t=%0t got=%h exp=%h", $time, g, e);
      end
   endtask

   // address phase held until ready, then data phase until ready
   task bus(input logic wr, input logic [7:0] a, input logic [31:0] wd);
      @(posedge mclk);
      hsel <= 1'b1;
      htrans <= 2'b10;
      hwrite <= wr;
      haddr <= {24'h0000, a};
      do @(posedge mclk); while (hreadyout !== 1'b1);
      htrans <= 2'b00;
      hwdata <= wd;
      do @(posedge mclk); while (hreadyout !== 1'b1);
      rd = hrdata;
   endtask

   task irqChk(input logic e);
      repeat (2) @(posedge mclk);
      #1;
      chk({31'h0000_0000, irq}, {31'h0000_0000, e});
   endtask

   // reference model, then execute and read back
   task run(input logic [31:0] i);
      logic [4:0] a, b, c, d;
      logic       ok;
      a = i[25:21];
      b = i[20:16];
      c = i[15:11];
      d = b;
      ok = 1'b1;
      if (i[31:26] != 6'd31) ok = 1'b0;
      else if (i[10:1] == 10'd476) r = ~(regs[a] & regs[c]);
      else if (i[10:1] == 10'd124) r = ~(regs[a] | regs[c]);
      else if (i[9:1] == 9'd104 || i[9:1] == 9'd488) begin
         d = a;
         s = regs[b];
         r = (i[9] && s[31]) ? s : ~s + 32'h0000_0001;
         if (i[10]) begin
            ovfFlag = !i[9] && s == 32'h8000_0000;
            sumOvf = sumOvf | ovfFlag;
            stat[1] = stat[1] | ovfFlag;
         end
      end else ok = 1'b0;
      stat[0] = 1'b1;
      if (!ok) stat[2] = 1'b1;
      if (ok) regs[d] = r;
      if (ok && i[0]) cr = {r[31], !r[31] && r != 0, r == 0, sumOvf};
      bus(1'b1, 8'h80, i);
      bus(1'b0, {1'b0, d, 2'b00}, 32'h0000_0000);
      chk(rd, regs[d]);
      bus(1'b0, 8'h84, 32'h0000_0000);
      chk(rd, {sumOvf, ovfFlag, carryFlag, 29'h0});
      bus(1'b0, 8'h88, 32'h0000_0000);
      chk(rd, {28'h000_0000, cr});
      bus(1'b0, 8'h8C, 32'h0000_0000);
      chk(rd, {29'h0000_0000, stat});
   endtask

   initial begin
      mclk = 1'b0;
      forever #5 mclk = ~mclk;
   end

   initial begin
      repeat (20000) @(posedge mclk);
      mismatches++;
      print_verdict;
   end

   initial begin
      {rstn, hsel, hwrite, htrans, haddr, hwdata} = '0;
      hsize = 3'b010;
      {mismatches, compares} = '0;
      {sumOvf, ovfFlag, carryFlag, cr, stat} = '0;
      seed = 32'h0000_0942;
      repeat (2) @(posedge mclk);
      rstn <= 1'b1;
      for (int j = 0; j < 6; j++) begin
         bus(1'b0, 8'h84 + 8'(4 * j), 32'h0000_0000);
         chk(rd, 32'h0000_0000);
      end
      for (int j = 0; j < 32; j++) begin
         seed = nx(seed);
         bus(1'b1, 8'(4 * j), seed);
         regs[j] = seed;
      end
      // every op with each overflow-enable and record form
      for (int k = 0; k < 64; k++) begin
         seed = nx(seed);
         bus(1'b1, 8'h84, seed);
         {sumOvf, ovfFlag, carryFlag} = seed[31:29];
         if (k[4]) begin
            bus(1'b1, {1'b0, seed[20:16], 2'b00}, 32'h8000_0000);
            regs[seed[20:16]] = 32'h8000_0000;
         end
         run({6'd31, seed[25:11], k[1] ? {k[2], k[0] ? 9'd488 : 9'd104}
            : (k[0] ? 10'd124 : 10'd476), k[3]});
         bus(1'b1, 8'h90, 32'h0000_0007);
         stat = 3'b000;
      end
      bus(1'b1, 8'h94, 32'h0000_0004);
      bus(1'b0, 8'h94, 32'h0000_0000);
      chk(rd, 32'h0000_0004);
      run(32'h0000_0000);
      irqChk(1'b1);
      bus(1'b1, 8'h94, 32'h0000_0000);
      irqChk(1'b0);
      bus(1'b1, 8'h94, 32'h0000_0004);
      irqChk(1'b1);
      bus(1'b1, 8'h90, 32'h0000_0007);
      irqChk(1'b0);
      bus(1'b1, 8'hA0, 32'hFFFF_FFFF);
      bus(1'b0, 8'hA0, 32'h0000_0000);
      chk(rd, 32'h0000_0000);
      print_verdict;
   end
endmodule // fpnl_unit_bench

bind fpnl_unit fpnl_unit_monitor fpnl_unit_monitor_inst (.mclk(mclk),
   .rstn(rstn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
   .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready),
   .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .irq(irq));

// ===== verif/fpnl_unit_monitor.sv
module fpnl_unit_monitor (
   input wire        mclk,
   input wire        rstn,
   input wire        hsel,
   input wire [31:0] haddr,
   input wire [1:0]  htrans,
   input wire        hwrite,
   input wire [2:0]  hsize,
   input wire [31:0] hwdata,
   input wire        hready,
   input wire [31:0] hrdata,
   input wire        hreadyout,
   input wire        hresp,
   input wire        irq
);
   timeunit 1ns;
   timeprecision 1ns;
   default clocking cb @(posedge mclk); endclocking
   default disable iff (!rstn);
   wire       take = hsel & htrans[1] & hready;
   wire       rdTk = take & ~hwrite;
   wire       insWr = take & hwrite & (haddr[7:0] == 8'h80);
   wire [7:0] off = haddr[7:0];
   chk_resp_okay: assert property (hresp == 1'b0)
      else $error("response not okay");
   // capture and execute cycles only
   chk_insn_wait: assert property (insWr
      |=> !hreadyout [*2] ##1 hreadyout) else $error("insn wait wrong");
   chk_reg_nowait: assert property (take && !insWr
      |=> hreadyout) else $error("plain access stalled");
   chk_xer_layout: assert property (rdTk && off == 8'h84
      |=> hrdata[28:0] == 29'h0000_0000) else $error("flag bits wrong");
   chk_cr0_layout: assert property (rdTk && off == 8'h88
      |=> hrdata[31:4] == 28'h000_0000) else $error("field bits wrong");
   chk_stat_layout: assert property (rdTk && off == 8'h8C
      |=> hrdata[31:3] == 29'h0000_0000) else $error("status bits wrong");
   chk_clear_zero: assert property (rdTk && off == 8'h90
      |=> hrdata == 32'h0000_0000) else $error("clear reads nonzero");
   chk_unmap_zero: assert property (rdTk && off > 8'h98
      |=> hrdata == 32'h0000_0000) else $error("unmapped nonzero");
   cover property (insWr);
   cover property ($rose(irq));
   cover property ($fell(irq));
endmodule // fpnl_unit_monitor
